// ==== dac_feature_ctrl.sv ====
// Top of the DAC feature control: APB registers, reference, toggle, monitor, thermal
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module dac_feature_ctrl #(
  parameter int NUM_CH = dac_ctrl_pkg::CH_N,
  parameter bit NARROW = 1'b0
) (
  // Clock and reset
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   reset_n_i,
  // APB slave
  input  wire logic                                   psel_i,
  input  wire logic                                   penable_i,
  input  wire logic                                   pwrite_i,
  input  wire logic [dac_ctrl_pkg::AW-1:0]            paddr_i,
  input  wire logic [31:0]                            pwdata_i,
  output logic      [31:0]                            prdata_o,
  output logic                                        pready_o,
  output logic                                        pslverr_o,
  // Pins
  input  wire logic                                   output_update_strobe_n_i,
  input  wire logic                                   over_temp_i,
  output logic                                        busy_n_o,
  // Analog controls
  output logic                                        ref_internal_o,
  output logic                                        ref_high_o,
  output logic                                        amp_enable_o,
  output logic      [NUM_CH-1:0][dac_ctrl_pkg::DW-1:0] dac_code_o,
  // Monitor pin view
  output logic      [5:0]                             monitor_output_pin_route_o,
  output logic                                        monitor_output_pin_oe_n_o,
  output logic      [dac_ctrl_pkg::DW-1:0]            monitor_output_pin_code_o
);
  import dac_ctrl_pkg::*;

  localparam int GROUPS = (NUM_CH + 7) / 8;

  top_state_s  st;
  top_state_s  next_st;
  logic        access;
  logic        word_ctrl;
  logic [1:0]  word_sel;
  logic [5:0]  word_addr;
  logic        therm_en;
  logic        ref_int_bit;
  logic        ref_vsel_bit;
  logic [1:0]  tog_grp;
  logic [GROUPS-1:0] tog_en;

  ////////////////////////////////////////////////////////////////////////////
  // Control bit decode per variant

  always_comb begin
    therm_en     = NARROW ? st.ctrl[N_THERM_EN] : st.ctrl[W_THERM_EN];
    ref_int_bit  = NARROW ? st.ctrl[N_REF_INT]  : st.ctrl[W_REF_INT];
    ref_vsel_bit = NARROW ? st.ctrl[N_REF_VSEL] : st.ctrl[W_REF_VSEL];
    tog_grp[0]   = NARROW ? st.ctrl[N_TOG_LO]   : st.ctrl[W_TOG_LO];
    tog_grp[1]   = NARROW ? st.ctrl[N_TOG_HI]   : st.ctrl[W_TOG_HI];
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    assign tog_en[g] = tog_grp[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and control

  assign access    = psel_i && penable_i && !st.pready;
  assign word_sel  = pwdata_i[WORD_SEL_LO+1:WORD_SEL_LO];
  assign word_addr = pwdata_i[WORD_ADDR_LO+5:WORD_ADDR_LO];
  assign word_ctrl = (word_sel == SEL_CTRL) && (word_addr[3:0] == CTRL_ADDR);

  always_comb begin
    next_st         = st;
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    next_st.wr_a    = 1'b0;
    next_st.wr_b    = 1'b0;
    next_st.upd     = 1'b0;

    // Busy after reset; register writes, soft power-up and strobes are ignored until it ends, reads still answer
    if (!st.busy_n) begin
      next_st.busy_cnt = st.busy_cnt + 5'h01;
      next_st.busy_n   = (32'(st.busy_cnt) == BUSY_CYCLES - 1);
    end

    // Pin synchronisers
    next_st.strb_s1 = output_update_strobe_n_i;
    next_st.strb_s2 = st.strb_s1;
    next_st.strb_s3 = st.strb_s2;
    next_st.temp_s1 = over_temp_i;
    next_st.temp_s2 = st.temp_s1;

    // Falling strobe edge, dropped while busy
    next_st.upd = st.busy_n && st.strb_s3 && !st.strb_s2;

    if (access) begin
      if (pwrite_i) begin
        case (paddr_i)
          OFS_CTRL, OFS_STATUS: ;
          OFS_WORD: begin
            if (st.busy_n) begin
              if (word_ctrl) begin
                next_st.ctrl = pwdata_i[DW-1:0];
              end
              next_st.wr_a    = (word_sel == SEL_DATA_A) && (32'(word_addr) < NUM_CH);
              next_st.wr_b    = (word_sel == SEL_DATA_B) && (32'(word_addr) < NUM_CH);
              next_st.wr_ch   = word_addr;
              next_st.wr_data = pwdata_i[DW-1:0];
            end
          end
          OFS_MON: begin
            if (st.busy_n) begin
              next_st.mon_en   = pwdata_i[MON_EN_BIT];
              next_st.mon_addr = pwdata_i[5:0];
            end
          end
          OFS_ACTION: ;
          default: next_st.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr_i)
          OFS_CTRL:   next_st.prdata = {18'h00000, st.ctrl};
          OFS_WORD:   next_st.prdata = 32'h00000000;
          OFS_MON:    next_st.prdata = {25'h0000000, st.mon_en, st.mon_addr};
          OFS_ACTION: next_st.prdata = 32'h00000000;
          OFS_STATUS: next_st.prdata = {27'h0000000, st.ref_high, st.ref_int,
                                        st.temp_s2, st.shutdown, st.busy_n};
          default: begin
            next_st.prdata  = 32'h00000000;
            next_st.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Thermal latch: clear by soft power-up when cool or by disable
    if (!therm_en) begin
      next_st.shutdown = 1'b0;
    end else if (access && pwrite_i && paddr_i == OFS_ACTION && st.busy_n
                 && pwdata_i[ACT_SOFT_UP] && !st.temp_s2) begin
      next_st.shutdown = 1'b0;
    end
    // Trip wins over any clear in the same cycle
    if (therm_en && st.temp_s2) begin
      next_st.shutdown = 1'b1;
    end

    next_st.amp_en   = !st.shutdown;
    next_st.ref_int  = ref_int_bit;
    next_st.ref_high = ref_vsel_bit;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st          <= '0;
      st.ctrl     <= CTRL_RESET;
      st.mon_addr <= MON_HIZ;
      st.strb_s1  <= 1'b1;
      st.strb_s2  <= 1'b1;
      st.strb_s3  <= 1'b1;
      st.amp_en   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o       = st.prdata;
  assign pready_o       = st.pready;
  assign pslverr_o      = st.pslverr;
  assign busy_n_o       = st.busy_n;
  assign ref_internal_o = st.ref_int;
  assign ref_high_o     = st.ref_high;
  assign amp_enable_o   = st.amp_en;

  ////////////////////////////////////////////////////////////////////////////
  // Channels and monitor

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dac_channel u_ch (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .toggle_en_i (tog_en[c/8]),
      .update_i    (st.upd),
      .wr_a_i      (st.wr_a && 32'(st.wr_ch) == c),
      .wr_b_i      (st.wr_b && 32'(st.wr_ch) == c),
      .data_i      (st.wr_data),
      .dac_o       (dac_code_o[c])
    );
  end

  monitor_mux #(.NUM_CH(NUM_CH)) u_mon (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .enable_i  (st.mon_en),
    .addr_i    (st.mon_addr),
    .codes_i   (dac_code_o),
    .route_o   (monitor_output_pin_route_o),
    .oe_n_o    (monitor_output_pin_oe_n_o),
    .code_o    (monitor_output_pin_code_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ref_follows_ctrl: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !ref_int_bit |=> !ref_internal_o)
    else $error("Internal reference on without control bit");

  a_ctrl_word_decode: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    access && pwrite_i && paddr_i == OFS_WORD && word_ctrl && busy_n_o
    |=> st.ctrl == $past(pwdata_i[DW-1:0]))
    else $error("Control write not decoded");

  a_thermal_trip: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    therm_en && st.temp_s2 |=> st.shutdown ##1 !amp_enable_o)
    else $error("Amplifiers not powered down on over temperature");

  a_shutdown_holds: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    st.shutdown && therm_en && !(access && pwrite_i && paddr_i == OFS_ACTION)
    |=> st.shutdown)
    else $error("Shutdown released without soft power-up");

  a_busy_blocks_strobe: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !busy_n_o |=> !st.upd)
    else $error("Strobe taken while busy");

  a_busy_length: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(busy_n_o) |-> $past(st.busy_cnt) == 5'(BUSY_CYCLES - 1))
    else $error("Busy period has wrong length");

  a_ref_int_on: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ref_int_bit |=> ref_internal_o)
    else $error("Internal reference not selected by control bit");

  a_ref_voltage: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    1'b1 |=> ref_high_o == $past(ref_vsel_bit))
    else $error("Reference voltage does not follow control bit");

  a_ctrl_write_only: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !(access && pwrite_i && paddr_i == OFS_WORD && word_ctrl && st.busy_n)
    |=> $stable(st.ctrl))
    else $error("Control bits changed without a control word");

  a_mon_routes_chan: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    st.mon_en && 32'(st.mon_addr) < NUM_CH
    |=> !monitor_output_pin_oe_n_o && monitor_output_pin_route_o == $past(st.mon_addr))
    else $error("Enabled channel address not routed");

  a_mon_code_chan: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    st.mon_en && 32'(st.mon_addr) < NUM_CH
    |=> monitor_output_pin_code_o == $past(dac_code_o[st.mon_addr[$clog2(NUM_CH)-1:0]]))
    else $error("Monitor code is not the routed channel");

  a_mon_ext_input: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    st.mon_en && (st.mon_addr == MON_EXT1 || st.mon_addr == MON_EXT2)
    |=> !monitor_output_pin_oe_n_o)
    else $error("External monitor input not routed");

  a_amp_follows_latch: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    st.shutdown |=> !amp_enable_o)
    else $error("Amplifiers on during shutdown");

  a_soft_up_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    therm_en && access && pwrite_i && paddr_i == OFS_ACTION && st.busy_n
    && pwdata_i[ACT_SOFT_UP] && !st.temp_s2 |=> !st.shutdown)
    else $error("Soft power-up did not clear shutdown");

  a_therm_off_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !therm_en |=> !st.shutdown)
    else $error("Shutdown kept with thermal monitor off");

  a_busy_writes_ignored: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !st.busy_n |=> $stable(st.ctrl) && $stable(st.mon_en) && $stable(st.mon_addr))
    else $error("Register write taken while busy");

  a_trip_needs_sync: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !st.temp_s2 && !st.shutdown |=> !st.shutdown)
    else $error("Shutdown set without synchronised flag");

endmodule : dac_feature_ctrl

// ==== dac_ctrl_pkg.sv ====
// Shared constants and state records of the DAC feature control block
package dac_ctrl_pkg;

  localparam int CH_N        = 16;
  localparam int DW          = 14;
  localparam int AW          = 8;
  localparam int BUSY_CYCLES = 16;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_WORD   = 8'h04;
  localparam logic [AW-1:0] OFS_MON    = 8'h08;
  localparam logic [AW-1:0] OFS_ACTION = 8'h0c;
  localparam logic [AW-1:0] OFS_STATUS = 8'h10;

  // Command word layout
  localparam int WORD_SEL_LO  = 22;
  localparam int WORD_ADDR_LO = 16;
  localparam logic [1:0] SEL_CTRL   = 2'h0;
  localparam logic [1:0] SEL_DATA_B = 2'h2;
  localparam logic [1:0] SEL_DATA_A = 2'h3;
  localparam logic [3:0] CTRL_ADDR  = 4'hc;

  // Control bit positions, wide (14-bit) and narrow (12-bit) variants
  localparam int W_REF_VSEL = 12;
  localparam int W_REF_INT  = 10;
  localparam int W_THERM_EN = 8;
  localparam int W_TOG_HI   = 3;
  localparam int W_TOG_LO   = 2;
  localparam int N_REF_VSEL = 10;
  localparam int N_REF_INT  = 8;
  localparam int N_THERM_EN = 6;
  localparam int N_TOG_HI   = 1;
  localparam int N_TOG_LO   = 0;
  localparam logic [DW-1:0] CTRL_RESET = 14'h0000;

  // Monitor register and channel addresses
  localparam int MON_EN_BIT = 6;
  localparam logic [5:0] MON_HIZ  = 6'h3f;
  localparam logic [5:0] MON_EXT1 = 6'h20;
  localparam logic [5:0] MON_EXT2 = 6'h21;

  localparam int ACT_SOFT_UP = 0;

  typedef struct packed {
    logic [DW-1:0] a;
    logic [DW-1:0] b;
    logic [DW-1:0] dac;
    logic          dirty;
    logic          phase;
    logic          tog_q;
  } chan_state_s;

  typedef struct packed {
    logic [5:0]    route;
    logic          oe_n;
    logic [DW-1:0] code;
  } mon_state_s;

  typedef struct packed {
    logic [DW-1:0] ctrl;
    logic          mon_en;
    logic [5:0]    mon_addr;
    logic [4:0]    busy_cnt;
    logic          busy_n;
    logic          strb_s1;
    logic          strb_s2;
    logic          strb_s3;
    logic          temp_s1;
    logic          temp_s2;
    logic          shutdown;
    logic          amp_en;
    logic          ref_int;
    logic          ref_high;
    logic          upd;
    logic          wr_a;
    logic          wr_b;
    logic [5:0]    wr_ch;
    logic [DW-1:0] wr_data;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } top_state_s;

endpackage : dac_ctrl_pkg

// ==== dac_channel.sv ====
// One DAC channel: A and B input registers, DAC register, toggle phase
`timescale 1ns/1ps
module dac_channel (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  // Control
  input  wire logic                      toggle_en_i,
  input  wire logic                      update_i,
  input  wire logic                      wr_a_i,
  input  wire logic                      wr_b_i,
  input  wire logic [dac_ctrl_pkg::DW-1:0] data_i,
  // Output
  output logic      [dac_ctrl_pkg::DW-1:0] dac_o
);
  import dac_ctrl_pkg::*;

  chan_state_s st;
  chan_state_s next_st;

  always_comb begin
    next_st = st;
    if (update_i) begin
      if (toggle_en_i) begin
        next_st.dac   = st.phase ? st.b : st.a;
        next_st.phase = ~st.phase;
        next_st.dirty = 1'b0;
      end else if (st.dirty) begin
        next_st.dac   = st.a;
        next_st.dirty = 1'b0;
      end
    end
    // A write landing with a strobe still counts for the next strobe
    if (wr_a_i) begin
      next_st.a     = data_i;
      next_st.dirty = 1'b1;
    end
    if (wr_b_i && toggle_en_i) begin
      next_st.b = data_i;
    end
    if (!toggle_en_i) begin
      next_st.phase = 1'b0;
    end
    if (st.tog_q && !toggle_en_i) begin
      next_st.dirty = 1'b1;
    end
    next_st.tog_q = toggle_en_i;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dac_o = st.dac;

  a_b_write_blocked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    wr_b_i && !toggle_en_i |=> $stable(st.b))
    else $error("B register changed with toggle disabled");

  a_toggle_first_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    update_i && toggle_en_i && !st.phase |=> dac_o == $past(st.a) ##0 st.phase)
    else $error("First toggle strobe did not load A");

  a_clean_keeps_dac: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    update_i && !toggle_en_i && !st.dirty |=> $stable(dac_o))
    else $error("DAC refreshed without a new write");

endmodule : dac_channel

// ==== monitor_mux.sv ====
// Monitor multiplexer: routes one channel or external input to the monitor pin
`timescale 1ns/1ps
module monitor_mux #(
  parameter int NUM_CH = dac_ctrl_pkg::CH_N
) (
  // Clock and reset
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   reset_n_i,
  // Selection
  input  wire logic                                   enable_i,
  input  wire logic [5:0]                             addr_i,
  input  wire logic [NUM_CH-1:0][dac_ctrl_pkg::DW-1:0] codes_i,
  // Monitor pin view
  output logic      [5:0]                             route_o,
  output logic                                        oe_n_o,
  output logic      [dac_ctrl_pkg::DW-1:0]            code_o
);
  import dac_ctrl_pkg::*;

  mon_state_s st;
  mon_state_s next_st;
  logic       is_chan;
  logic       is_ext;

  always_comb begin
    is_chan       = 32'(addr_i) < NUM_CH;
    is_ext        = (addr_i == MON_EXT1) || (addr_i == MON_EXT2);
    next_st       = st;
    next_st.route = addr_i;
    next_st.code  = is_chan ? codes_i[addr_i[$clog2(NUM_CH)-1:0]] : '0;
    // Pin floats unless enabled and pointed at a real source
    next_st.oe_n  = !enable_i || (addr_i == MON_HIZ) || !(is_chan || is_ext);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '{route: MON_HIZ, oe_n: 1'b1, code: '0};
    end else begin
      st <= next_st;
    end
  end

  assign route_o = st.route;
  assign oe_n_o  = st.oe_n;
  assign code_o  = st.code;

  a_mon_disabled_hiz: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !enable_i |=> oe_n_o)
    else $error("Monitor drives while disabled");

  a_mon_reserved_hiz: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    enable_i && addr_i == MON_HIZ |=> oe_n_o && route_o == MON_HIZ)
    else $error("Reserved monitor address did not float the pin");

endmodule : monitor_mux

// ==== host_pins.sv ====
// Host-side pin model: update strobe driver and over-temperature comparator stand-in
`timescale 1ns/1ps
module host_pins (
  // Clock
  input  wire logic ref_clk_i,
  // Pins toward the block
  output logic      output_update_strobe_n_o,
  output logic      over_temp_o
);

  initial begin
    output_update_strobe_n_o = 1'b1;
    over_temp_o              = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // With toggle on, each pulse switches the data source, so the pulse rate sets the wave frequency
  task automatic strobe;
    @(posedge ref_clk_i);
    output_update_strobe_n_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    output_update_strobe_n_o <= 1'b1;
    // Sync plus update takes four edges from the falling strobe
    repeat (6) @(posedge ref_clk_i);
  endtask : strobe

  // Comparator level, held long enough to pass the synchroniser
  task automatic set_temp(input logic hot);
    @(posedge ref_clk_i);
    over_temp_o <= hot;
    repeat (8) @(posedge ref_clk_i);
  endtask : set_temp

endmodule : host_pins

// ==== tb_dac_feature_ctrl.sv ====
// Self-checking bench for the DAC feature control block
`timescale 1ns/1ps
module tb_dac_feature_ctrl;
  import dac_ctrl_pkg::*;

  logic                     clk     = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     psel    = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite  = 1'b0;
  logic [AW-1:0]            paddr   = '0;
  logic [31:0]              pwdata  = '0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     strobe_n;
  logic                     over_temp;
  logic                     busy_n;
  logic                     ref_int;
  logic                     ref_high;
  logic                     amp_en;
  logic [CH_N-1:0][DW-1:0]  dac;
  logic [5:0]               route;
  logic                     mon_oe_n;
  logic [DW-1:0]            mon_code;
  logic                     ref_int_narrow;
  logic                     ref_high_narrow;
  logic                     amp_en_narrow;
  logic [CH_N-1:0][DW-1:0]  dac_narrow;
  int                       miscompares = 0;
  int                       n_tests     = 0;

  always #10 clk = ~clk;

  dac_feature_ctrl #(.NUM_CH(CH_N), .NARROW(1'b0)) uut (
    .ref_clk_i(clk), .reset_n_i(reset_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .output_update_strobe_n_i(strobe_n), .over_temp_i(over_temp), .busy_n_o(busy_n),
    .ref_internal_o(ref_int), .ref_high_o(ref_high), .amp_enable_o(amp_en),
    .dac_code_o(dac), .monitor_output_pin_route_o(route),
    .monitor_output_pin_oe_n_o(mon_oe_n), .monitor_output_pin_code_o(mon_code)
  );

  host_pins pins (
    .ref_clk_i(clk), .output_update_strobe_n_o(strobe_n), .over_temp_o(over_temp)
  );

  // Narrow layout twin on the same bus and pins; only its decoded outputs are watched
  dac_feature_ctrl #(.NUM_CH(CH_N), .NARROW(1'b1)) uut_narrow (
    .ref_clk_i(clk), .reset_n_i(reset_n),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(),
    .output_update_strobe_n_i(strobe_n), .over_temp_i(over_temp), .busy_n_o(),
    .ref_internal_o(ref_int_narrow), .ref_high_o(ref_high_narrow),
    .amp_enable_o(amp_en_narrow), .dac_code_o(dac_narrow), .monitor_output_pin_route_o(),
    .monitor_output_pin_oe_n_o(), .monitor_output_pin_code_o()
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, eerr});
    // One idle edge so the next request is not assigned in this step
    @(posedge clk);
  endtask : rd_chk

  function automatic logic [31:0] cmd(input logic [1:0] sel, input logic [5:0] a,
                                      input logic [13:0] d);
    return {8'h00, sel, a, 2'h0, d};
  endfunction : cmd

  task automatic ctl(input logic [13:0] d);
    wr(OFS_WORD, cmd(SEL_CTRL, {2'h0, CTRL_ADDR}, d));
  endtask : ctl

  task automatic mon(input logic [31:0] v, input logic [5:0] r, input logic oe_n,
                     input logic [13:0] c);
    wr(OFS_MON, v);
    chk(mon_oe_n, oe_n);
    chk(route, r);
    if (!oe_n) chk(mon_code, c);
  endtask : mon

  task automatic wait_busy;
    int n;
    n = 0;
    while (busy_n !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(busy_n, 1'b1);
  endtask : wait_busy

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    miscompares++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge clk);
    chk(busy_n, 1'b0);
    chk(ref_int, 1'b0);
    reset_n <= 1'b1;
    wait_busy;
    rd_chk(OFS_STATUS, 32'h1, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    wr(OFS_WORD, cmd(SEL_CTRL, 6'h0d, 14'h1400));
    chk(ref_int, 1'b0);
    // Five-volt supply assumed, so the high reference voltage
    ctl(14'h1400);
    chk({ref_int, ref_high}, 2'h3);
    chk({ref_int_narrow, ref_high_narrow}, 2'h1);
    rd_chk(OFS_CTRL, 32'h1400, 1'b0);
    wr(OFS_CTRL, 32'h0);
    ctl(14'h0400);
    chk({ref_int, ref_high}, 2'h2);
    // Toggle only the low group; B writes elsewhere are dropped
    wr(OFS_WORD, cmd(SEL_DATA_B, 6'd1, 14'h0333));
    ctl(14'h0404);
    wr(OFS_WORD, cmd(SEL_DATA_A, 6'd0, 14'h0111));
    wr(OFS_WORD, cmd(SEL_DATA_A, 6'd1, 14'h0044));
    wr(OFS_WORD, cmd(SEL_DATA_A, 6'd8, 14'h0088));
    wr(OFS_WORD, cmd(SEL_DATA_B, 6'd0, 14'h0222));
    wr(OFS_WORD, cmd(SEL_DATA_B, 6'd8, 14'h0777));
    pins.strobe();
    chk(dac[0], 14'h0111);
    chk(dac[1], 14'h0044);
    chk(dac[8], 14'h0088);
    pins.strobe();
    chk(dac[0], 14'h0222);
    chk(dac[1], 14'h0000);
    chk(dac[8], 14'h0088);
    chk(dac_narrow[1], 14'h0044);
    ctl(14'h0400);
    pins.strobe();
    chk(dac[0], 14'h0111);
    chk(dac[1], 14'h0044);
    // Monitor routing
    mon(32'h00, 6'h00, 1'b1, 14'h0);
    mon(32'h40, 6'h00, 1'b0, 14'h0111);
    mon(32'h48, 6'h08, 1'b0, 14'h0088);
    mon(32'h60, MON_EXT1, 1'b0, 14'h0);
    mon(32'h61, MON_EXT2, 1'b0, 14'h0);
    mon(32'h7f, MON_HIZ, 1'b1, 14'h0);
    rd_chk(OFS_MON, 32'h7f, 1'b0);
    // Thermal shutdown and recovery
    pins.set_temp(1'b1);
    chk(amp_en, 1'b1);
    ctl(14'h0500);
    repeat (4) @(posedge clk);
    chk(amp_en, 1'b0);
    chk(amp_en_narrow, 1'b1);
    chk({ref_int_narrow, ref_high_narrow}, 2'h3);
    rd_chk(OFS_STATUS, 32'h0f, 1'b0);
    wr(OFS_ACTION, 32'h1);
    chk(amp_en, 1'b0);
    pins.set_temp(1'b0);
    chk(amp_en, 1'b0);
    wr(OFS_ACTION, 32'h1);
    chk(amp_en, 1'b1);
    pins.set_temp(1'b1);
    chk(amp_en, 1'b0);
    ctl(14'h0400);
    chk(amp_en, 1'b1);
    pins.set_temp(1'b0);
    // Hardware reset in mid-run brings back the defaults
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(busy_n, 1'b0);
    chk({ref_int, dac[0]}, 15'h0);
    pins.strobe();
    wait_busy;
    chk(dac[0], 14'h0);
    rd_chk(OFS_CTRL, 32'h0, 1'b0);
    rd_chk(OFS_MON, {26'h0, MON_HIZ}, 1'b0);
    wr(OFS_WORD, cmd(SEL_DATA_A, 6'd0, 14'h0555));
    repeat (8) @(posedge clk);
    chk(dac[0], 14'h0);
    pins.strobe();
    chk(dac[0], 14'h0555);
    test_done;
  end

endmodule : tb_dac_feature_ctrl
